// ===== inc/hlem_pkg.sv
// Constants shared by the link event, status and mask block
package hlem_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_LATCHED = 8'h0D;
  localparam logic [7:0] OFS_STATUS = 8'h0E;
  localparam logic [7:0] OFS_MASK = 8'h0F;
  // Field positions
  localparam int RXM_HI = 7;
  localparam int RXM_LO = 5;
  localparam int RXF_HI = 4;
  localparam int RXF_LO = 3;
  localparam int TXF_HI = 2;
  localparam int TXF_LO = 1;
  localparam int TXS_BIT = 0;
  // Reset values
  localparam logic [7:0] LATCHED_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // Largest valid message in bytes
  localparam logic [7:0] MSG_MAX_BYTES = 8'h80;
  // Receive message codes
  localparam logic [2:0] RXM_IDLE = 3'h0;
  localparam logic [2:0] RXM_START = 3'h1;
  localparam logic [2:0] RXM_VALID = 3'h2;
  localparam logic [2:0] RXM_CRCERR = 3'h3;
  localparam logic [2:0] RXM_ABORT = 3'h4;
  // Receive FIFO codes
  localparam logic [1:0] RXF_LOW = 2'h0;
  localparam logic [1:0] RXF_HALF = 2'h1;
  localparam logic [1:0] RXF_FULL = 2'h2;
  localparam logic [1:0] RXF_OVF = 2'h3;
  // Transmit FIFO codes
  localparam logic [1:0] TXF_HALF = 2'h0;
  localparam logic [1:0] TXF_LOW = 2'h1;
  localparam logic [1:0] TXF_OVF = 2'h2;
  localparam logic [1:0] TXF_UNF = 2'h3;
endpackage

// ===== verification/hlem_link_events_test.sv
// Self-checking bench for the link event latch, status and mask block
`timescale 1ns/1ns
`default_nettype none
module hlem_link_events_test;
  import hlem_pkg::*;
  logic clock_i, rst_n_i, wr_i, rd_i, irq_o, irq_m, live, rs;
  logic [7:0] addr_i, wdata_i, rdata_o, len_i, st_m, lat_m, mask_m, rd_m, ns, nl;
  // Condition vector: 0 rise, 1 fall, 2 global mask, 3/4 half enables, 5..15 conditions, 16 clock enable
  logic [16:0] c, cn;
  logic [31:0] seed;
  int errors, total_checks, cycles;

  //////////////////////////////////////////////////////////////////////////////
  // Design under test
  hlem_link_events DUT (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(c[16]), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .irq_o(irq_o), .rise_en_i(c[0]), .fall_en_i(c[1]),
    .global_irq_mask_i(c[2]), .rx_half_level_irq_en_i(c[3]), .tx_half_level_irq_en_i(c[4]),
    .rx_start_i(c[5]), .rx_good_crc_i(c[6]), .rx_msg_len_i(len_i), .rx_crc_err_i(c[7]), .rx_abort_i(c[8]),
    .rx_fifo_half_i(c[9]), .rx_fifo_full_i(c[10]), .rx_fifo_ovf_i(c[11]), .tx_fifo_below_half_i(c[12]),
    .tx_fifo_ovf_i(c[13]), .tx_fifo_unf_i(c[14]), .tx_msg_done_i(c[15])
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next pseudo-random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected current status from the condition vector
  function automatic logic [7:0] stat_f(input logic [16:0] v, input logic [7:0] len);
    logic [2:0] m;
    logic [1:0] rf;
    logic [1:0] tf;
    logic svc;
    svc = v[10] | v[11] | (v[3] & v[9]);
    if (v[8]) m = RXM_ABORT;
    else if (v[7]) m = RXM_CRCERR;
    else if ((v[6] && len <= MSG_MAX_BYTES) || svc) m = RXM_VALID;
    else if (v[5]) m = RXM_START;
    else m = RXM_IDLE;
    rf = v[11] ? RXF_OVF : v[10] ? RXF_FULL : v[9] ? RXF_HALF : RXF_LOW;
    tf = v[14] ? TXF_UNF : v[13] ? TXF_OVF : v[12] ? TXF_LOW : TXF_HALF;
    return {m, rf, tf, v[15] | (v[4] ? v[12] : v[14])};
  endfunction

  // Expected latched value: a field loads a nonzero new code on a selected edge
  function automatic logic [7:0] latch_f(input logic [7:0] lat, old, cur, input logic r, f);
    logic [7:0] fm;
    for (int i = 0; i < 4; i++) begin
      fm = (i == 0) ? 8'hE0 : (i == 1) ? 8'h18 : (i == 2) ? 8'h06 : 8'h01;
      if (((r && |(~old & cur & fm)) || (f && |(old & ~cur & fm))) && (i == 3 || |(cur & fm))) begin
        lat = (lat & ~fm) | ((i == 3) ? fm : (cur & fm));
      end
    end
    return lat;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Clock at 20 MHz
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Reference model, updated on the same edges as the design
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      st_m = STATUS_RST;
      lat_m = LATCHED_RST;
      mask_m = MASK_RST;
      rd_m = RDATA_RST;
      irq_m = 1'b0;
    end else if (c[16]) begin
      irq_m = |(lat_m & ~mask_m) & ~c[2];
      if (rd_i) begin
        rd_m = (addr_i == OFS_LATCHED) ? lat_m : (addr_i == OFS_STATUS) ? st_m :
               (addr_i == OFS_MASK) ? mask_m : UNMAPPED_RD;
      end
      ns = stat_f(c, len_i);
      nl = (wr_i && addr_i == OFS_LATCHED) ? (lat_m & wdata_i) : lat_m;
      lat_m = latch_f(nl, st_m, ns, c[0], c[1]);
      if (wr_i && addr_i == OFS_MASK) mask_m = wdata_i;
      st_m = ns;
    end
  end

  // Compare outputs with the model in every cycle
  always @(negedge clock_i) begin
    if (live) begin
      check("read data", rdata_o, rd_m);
      check("interrupt", {7'h00, irq_o}, {7'h00, irq_m});
    end
  end

  // Cut a hang short
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compare one value with its expectation
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Drive every input for one cycle
  task automatic cyc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    rst_n_i <= rs;
    c <= cn;
    len_i <= seed[31:24];
    rd_i <= r;
    wr_i <= w;
    addr_i <= a;
    wdata_i <= d;
  endtask

  // Read a register and compare it after its answer cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
    cyc(1'b1, 1'b0, a, 8'h00);
    cyc(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge clock_i);
    check("register", rdata_o, exp);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    c = '0;
    cn = 17'h10000;
    rs = 1'b0;
    rst_n_i = 1'b0;
    {rd_i, wr_i, addr_i, wdata_i, len_i} = '0;
    seed = 32'hC38ECA52;
    {live, errors, total_checks, cycles} = '0;
    repeat (6) cyc(1'b0, 1'b0, 8'h00, 8'h00);
    rs = 1'b1;
    live = 1'b1;
    rd_chk(OFS_LATCHED, LATCHED_RST);
    rd_chk(OFS_MASK, MASK_RST);
    // Abort on a rising edge, then idle, then clear by writing 0
    cn = 17'h10001;
    cyc(1'b0, 1'b1, OFS_MASK, 8'h00);
    cn = 17'h10101;
    rd_chk(OFS_LATCHED, 8'h80);
    check("irq on", {7'h00, irq_o}, 8'h01);
    cn = 17'h10001;
    rd_chk(OFS_LATCHED, 8'h80);
    cyc(1'b0, 1'b1, OFS_LATCHED, 8'hFF);
    rd_chk(OFS_LATCHED, 8'h80);
    cyc(1'b0, 1'b1, OFS_LATCHED, 8'h7F);
    rd_chk(OFS_LATCHED, 8'h00);
    // Every edge selection on the receive FIFO field
    for (int m = 0; m < 4; m++) begin
      cn = {1'b1, 14'h0000, m[1:0]};
      cyc(1'b0, 1'b1, OFS_LATCHED, 8'h00);
      cn[11] = 1'b1;
      rd_chk(OFS_LATCHED, m[0] ? 8'h58 : 8'h00);
      cyc(1'b0, 1'b1, OFS_LATCHED, 8'h00);
      cn = {1'b1, 5'h00, 1'b1, 8'h00, m[1:0]};
      rd_chk(OFS_LATCHED, m[1] ? 8'h10 : 8'h00);
    end
    // Status is read-only; unmapped places ignore writes and read zero
    cyc(1'b0, 1'b1, OFS_STATUS, 8'hFF);
    rd_chk(OFS_STATUS, 8'h50);
    cyc(1'b0, 1'b1, 8'h20, 8'hFF);
    rd_chk(8'h20, UNMAPPED_RD);
    cn = 17'h11010;
    rd_chk(OFS_STATUS, 8'h03);
    cn = 17'h14000;
    rd_chk(OFS_STATUS, 8'h07);
    cn = 17'h10208;
    rd_chk(OFS_STATUS, 8'h48);
    // Random traffic with a reset in mid-run
    for (int i = 0; i < 4000; i++) begin
      seed = lfsr(seed);
      cn = {seed[20:18] != 3'h0, seed[15:0]};
      rs = (i < 2000) || (i > 2002);
      cyc(seed[21], seed[22] & seed[23],
          (seed[25:24] == 2'h3) ? seed[31:24] : OFS_LATCHED + {6'h00, seed[25:24]}, seed[7:0] ^ seed[31:24]);
    end
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== verilog/hlem_link_events.sv
// Link event latch, current status and mask registers
`timescale 1ns/1ns
`default_nettype none
module hlem_link_events (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [hlem_pkg::ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [hlem_pkg::DATA_W-1:0] wdata_i,
  output logic [hlem_pkg::DATA_W-1:0] rdata_o,
  output logic irq_o,
  input wire logic rise_en_i,
  input wire logic fall_en_i,
  input wire logic global_irq_mask_i,
  input wire logic rx_half_level_irq_en_i,
  input wire logic tx_half_level_irq_en_i,
  input wire logic rx_start_i,
  input wire logic rx_good_crc_i,
  input wire logic [7:0] rx_msg_len_i,
  input wire logic rx_crc_err_i,
  input wire logic rx_abort_i,
  input wire logic rx_fifo_half_i,
  input wire logic rx_fifo_full_i,
  input wire logic rx_fifo_ovf_i,
  input wire logic tx_fifo_below_half_i,
  input wire logic tx_fifo_ovf_i,
  input wire logic tx_fifo_unf_i,
  input wire logic tx_msg_done_i
);
  import hlem_pkg::*;

  ////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] status_d;
  logic [7:0] status_q;
  logic [7:0] latched_d;
  logic [7:0] latched_q;
  logic [7:0] mask_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic [7:0] keep_mask;
  logic wr_lat;
  logic wr_mask;
  logic rx_valid_msg;
  logic rx_service;
  logic tx_service;
  logic [2:0] rxf_upd;
  logic [2:0] txf_upd;
  logic txs_trig;

  // Next value of one latched field from old, new and prior code
  function automatic logic [2:0] lat_upd(
    input logic [2:0] old_v,
    input logic [2:0] cur_v,
    input logic [2:0] prev_v,
    input logic [2:0] keep_v,
    input logic rise_v,
    input logic fall_v
  );
    logic trig;
    trig = (rise_v && (|(cur_v & ~prev_v)))
        || (fall_v && (|(~cur_v & prev_v)));
    if (trig && (cur_v != 3'h0)) begin
      lat_upd = cur_v;
    end else begin
      lat_upd = old_v & keep_v;
    end
  endfunction

  ////////////////////////////////////////////////////////////
  // Current status encoding

  // Service terms and message validity
  always_comb begin
    rx_valid_msg = rx_good_crc_i && (rx_msg_len_i <= MSG_MAX_BYTES);
    if (rx_half_level_irq_en_i) begin
      rx_service = rx_fifo_half_i || rx_fifo_full_i || rx_fifo_ovf_i;
    end else begin
      rx_service = rx_fifo_full_i || rx_fifo_ovf_i;
    end
    if (tx_half_level_irq_en_i) begin
      tx_service = tx_msg_done_i || tx_fifo_below_half_i;
    end else begin
      tx_service = tx_msg_done_i || tx_fifo_unf_i;
    end
  end

  // Code fields, highest priority first
  always_comb begin
    status_d = STATUS_RST;
    if (rx_abort_i) begin
      status_d[RXM_HI:RXM_LO] = RXM_ABORT;
    end else if (rx_crc_err_i) begin
      status_d[RXM_HI:RXM_LO] = RXM_CRCERR;
    end else if (rx_valid_msg || rx_service) begin
      status_d[RXM_HI:RXM_LO] = RXM_VALID;
    end else if (rx_start_i) begin
      status_d[RXM_HI:RXM_LO] = RXM_START;
    end else begin
      status_d[RXM_HI:RXM_LO] = RXM_IDLE;
    end
    if (rx_fifo_ovf_i) begin
      status_d[RXF_HI:RXF_LO] = RXF_OVF;
    end else if (rx_fifo_full_i) begin
      status_d[RXF_HI:RXF_LO] = RXF_FULL;
    end else if (rx_fifo_half_i) begin
      status_d[RXF_HI:RXF_LO] = RXF_HALF;
    end else begin
      status_d[RXF_HI:RXF_LO] = RXF_LOW;
    end
    if (tx_fifo_unf_i) begin
      status_d[TXF_HI:TXF_LO] = TXF_UNF;
    end else if (tx_fifo_ovf_i) begin
      status_d[TXF_HI:TXF_LO] = TXF_OVF;
    end else if (tx_fifo_below_half_i) begin
      status_d[TXF_HI:TXF_LO] = TXF_LOW;
    end else begin
      status_d[TXF_HI:TXF_LO] = TXF_HALF;
    end
    status_d[TXS_BIT] = tx_service;
  end

  // Current status register, read-only to software
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_q <= STATUS_RST;
    end else if (ce_i) begin
      status_q <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////
  // Latched events

  // Write strobes and clear mask
  always_comb begin
    wr_lat = wr_i && (addr_i == OFS_LATCHED);
    wr_mask = wr_i && (addr_i == OFS_MASK);
    keep_mask = wr_lat ? wdata_i : 8'hFF;
  end

  // Each code field follows its code, the service bit sets on any selected edge; a new event beats a clear
  always_comb begin
    latched_d[RXM_HI:RXM_LO] = lat_upd(latched_q[RXM_HI:RXM_LO],
      status_d[RXM_HI:RXM_LO], status_q[RXM_HI:RXM_LO],
      keep_mask[RXM_HI:RXM_LO], rise_en_i, fall_en_i);
    rxf_upd = lat_upd({1'b0, latched_q[RXF_HI:RXF_LO]},
      {1'b0, status_d[RXF_HI:RXF_LO]}, {1'b0, status_q[RXF_HI:RXF_LO]},
      {1'b0, keep_mask[RXF_HI:RXF_LO]}, rise_en_i, fall_en_i);
    latched_d[RXF_HI:RXF_LO] = rxf_upd[1:0];
    txf_upd = lat_upd({1'b0, latched_q[TXF_HI:TXF_LO]},
      {1'b0, status_d[TXF_HI:TXF_LO]}, {1'b0, status_q[TXF_HI:TXF_LO]},
      {1'b0, keep_mask[TXF_HI:TXF_LO]}, rise_en_i, fall_en_i);
    latched_d[TXF_HI:TXF_LO] = txf_upd[1:0];
    // Single service bit sets on any selected transition, falling too
    txs_trig = (rise_en_i && status_d[TXS_BIT] && !status_q[TXS_BIT])
      || (fall_en_i && !status_d[TXS_BIT] && status_q[TXS_BIT]);
    latched_d[TXS_BIT] = txs_trig || (latched_q[TXS_BIT] && keep_mask[TXS_BIT]);
  end

  // Latched event register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      latched_q <= LATCHED_RST;
    end else if (ce_i) begin
      latched_q <= latched_d;
    end
  end

  ////////////////////////////////////////////////////////////
  // Mask, read port and interrupt

  // Mask register, fully writable
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mask_q <= MASK_RST;
    end else if (ce_i && wr_mask) begin
      mask_q <= wdata_i;
    end
  end

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_q <= RDATA_RST;
    end else if (ce_i && rd_i) begin
      if (addr_i == OFS_LATCHED) begin
        rdata_q <= latched_q;
      end else if (addr_i == OFS_STATUS) begin
        rdata_q <= status_q;
      end else if (addr_i == OFS_MASK) begin
        rdata_q <= mask_q;
      end else begin
        rdata_q <= UNMAPPED_RD;
      end
    end
  end

  // Single request from unmasked events, gated by global mask
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= (|(latched_q & ~mask_q)) && !global_irq_mask_i;
    end
  end

  assign rdata_o = rdata_q;
  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////
  // Assertions

  property p_no_edge_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && !rise_en_i && !fall_en_i && !wr_lat) |=> $stable(latched_q);
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold)
    else $error("latched changed with no edge selected");

  property p_irq;
    @(posedge clock_i) disable iff (!rst_n_i)
    ce_i |=> irq_o == ((|($past(latched_q) & ~$past(mask_q)))
      && !$past(global_irq_mask_i));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not match unmasked events");

  property p_gim;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && global_irq_mask_i) ##1 (ce_i && global_irq_mask_i) |=> !irq_o;
  endproperty
  a_gim: assert property (p_gim)
    else $error("interrupt raised under global mask");

  property p_all_masked;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && mask_q == 8'hFF) |=> !irq_o;
  endproperty
  a_all_masked: assert property (p_all_masked)
    else $error("interrupt raised with every event masked");

  property p_clear;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && wr_lat && status_d == status_q)
      |=> latched_q == ($past(latched_q) & $past(wdata_i));
  endproperty
  a_clear: assert property (p_clear)
    else $error("latched clear by write 0 failed");

  property p_rxm_zero_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && !wr_lat && status_d[RXM_HI:RXM_LO] == 3'h0)
      |=> $stable(latched_q[RXM_HI:RXM_LO]);
  endproperty
  a_rxm_zero_hold: assert property (p_rxm_zero_hold)
    else $error("receive message latch lost on zero code");

  property p_rxf_follow;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && rise_en_i && fall_en_i && status_d[RXF_HI:RXF_LO] != 2'h0
      && status_d[RXF_HI:RXF_LO] != status_q[RXF_HI:RXF_LO])
      |=> latched_q[RXF_HI:RXF_LO] == $past(status_d[RXF_HI:RXF_LO]);
  endproperty
  a_rxf_follow: assert property (p_rxf_follow)
    else $error("receive FIFO latch did not follow code");

  property p_txf_zero_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && !wr_lat && status_d[TXF_HI:TXF_LO] == 2'h0)
      |=> $stable(latched_q[TXF_HI:TXF_LO]);
  endproperty
  a_txf_zero_hold: assert property (p_txf_zero_hold)
    else $error("transmit FIFO latch lost on zero code");

  property p_status_read;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && rd_i && addr_i == OFS_STATUS) |=> rdata_o == $past(status_q);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read returned wrong value");

  property p_abort;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && rx_abort_i) |=> status_q[RXM_HI:RXM_LO] == RXM_ABORT;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort not reported in message code");

  property p_rx_ovf;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && rx_fifo_ovf_i) |=> status_q[RXF_HI:RXF_LO] == RXF_OVF;
  endproperty
  a_rx_ovf: assert property (p_rx_ovf)
    else $error("receive overflow code wrong");

  property p_tx_unf;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && tx_fifo_unf_i) |=> status_q[TXF_HI:TXF_LO] == TXF_UNF
      && (status_q[TXS_BIT] || $past(tx_half_level_irq_en_i));
  endproperty
  a_tx_unf: assert property (p_tx_unf)
    else $error("transmit underflow code or service wrong");

  property p_tx_done;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && tx_msg_done_i) |=> status_q[TXS_BIT];
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("transmit service missing on completion");

  property p_rx_half;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && rx_half_level_irq_en_i && rx_fifo_half_i && !rx_abort_i && !rx_crc_err_i)
      |=> status_q[RXM_HI:RXM_LO] == RXM_VALID;
  endproperty
  a_rx_half: assert property (p_rx_half)
    else $error("receive half service code missing");

  property p_tx_half_off;
    @(posedge clock_i) disable iff (!rst_n_i)
    (ce_i && !tx_half_level_irq_en_i && !tx_msg_done_i && !tx_fifo_unf_i)
      |=> !status_q[TXS_BIT];
  endproperty
  a_tx_half_off: assert property (p_tx_half_off)
    else $error("transmit service raised with half enable off");

endmodule
`default_nettype wire
